//--- hw/frb_pkg.sv
// frb_pkg: constants shared by the radio serial register bank.
// Assumes a 15-bit frame: 4 address bits followed by 11 data bits.
package frb_pkg;
  localparam int FRAME_BITS = 15;
  localparam int DATA_BITS = 11;
  localparam int WORD_BITS = 16;
  localparam logic [3:0] LAST_BIT_CNT = 4'hE;

  typedef logic [3:0] frb_addr_t;
  typedef logic [10:0] frb_data_t;

  // frame layout
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 11;

  // register addresses
  localparam frb_addr_t ADDR_FILTER = 4'h0;
  localparam frb_addr_t ADDR_CNT2 = 4'h1;
  localparam frb_addr_t ADDR_MAIN = 4'h2;
  localparam frb_addr_t ADDR_STCLK = 4'h3;
  localparam frb_addr_t ADDR_LATCH = 4'h4;
  localparam frb_addr_t ADDR_RFCAP = 4'h5;
  localparam frb_addr_t ADDR_IFOSC = 4'h6;
  localparam frb_addr_t ADDR_RFOSC = 4'h7;

  // field positions
  localparam int WIDTH_MSB = 10;
  localparam int WIDTH_LSB = 6;
  localparam int CENTER_MSB = 4;
  localparam int CENTER_LSB = 0;
  localparam int CNT2_EN_BIT = 0;
  localparam int DELAY_MSB = 3;
  localparam int DELAY_LSB = 1;
  localparam int SEL_MSB = 10;
  localparam int SEL_LSB = 7;
  localparam int STPLL_BIT = 6;
  localparam int DEMPLL_BIT = 5;
  localparam int INTEG_BIT = 4;
  localparam int MEAS_BIT = 3;
  localparam int AUDIO_MUTE_BIT = 2;
  localparam int RADIO_BIT = 1;
  localparam int LATCH_CNT_BIT = 10;
  localparam int LATCH_STS_BIT = 9;
  localparam int CLEAR_BIT = 4;

  // output select codes
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_RF_OSC = 4'h1;
  localparam logic [3:0] SEL_STEREO_CLK = 4'h5;
  localparam logic [3:0] SEL_STEREO_IND = 4'h7;
  localparam logic [3:0] SEL_IF_OSC = 4'h9;
  localparam logic [3:0] SEL_SHIFTER = 4'hB;

  // reset values and stop count base
  localparam frb_data_t REG_RST = 11'h000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] DELAY_BASE = 16'h0002;
endpackage

//--- hw/frb_link_if.sv
// frb_link_if: carries frames and shifter loads between the link and core.
// Assumes frame_word is stable whenever frame_tgl has settled.
`timescale 1ns/1ps
interface frb_link_if;
  logic [14:0] frame_word;
  logic frame_tgl;
  logic [15:0] load_word;
  logic load_tgl;
  logic shift_bit;

  modport link (
    output frame_word,
    output frame_tgl,
    output shift_bit,
    input load_word,
    input load_tgl
  );
  modport core (
    input frame_word,
    input frame_tgl,
    input shift_bit,
    output load_word,
    output load_tgl
  );
endinterface

//--- hw/frb_link.sv
// frb_link: serial frame receiver and read shifter on the serial clock.
// Assumes the host changes rw and data away from the rising serial edge.
`timescale 1ns/1ps
module frb_link (
  // link clock and reset
  input wire logic link_clk_i,
  input wire logic rst_i,
  // serial pins
  input wire logic rw_i,
  input wire logic data_i,
  output logic data_o,
  // core side
  frb_link_if.link lnk
);
  import frb_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
    logic [13:0] shift_in;
    logic [14:0] frame_word;
    logic frame_tgl;
    logic [15:0] serial_out_shifter;
    logic ld_sync1;
    logic ld_sync2;
    logic ld_seen;
  } frb_link_s;

  frb_link_s st_ff;
  frb_link_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ld_sync1 = lnk.load_tgl;
    nxt_st.ld_sync2 = st_ff.ld_sync1;
    // R16: high writes, low reads
    if (rw_i) begin
      // R01: fifteen clocks per frame
      if (st_ff.cnt == LAST_BIT_CNT) begin
        // R18: commit after last bit
        nxt_st.frame_word = {st_ff.shift_in, data_i};
        nxt_st.frame_tgl = ~st_ff.frame_tgl;
        nxt_st.cnt = 4'h0;
      end else begin
        nxt_st.shift_in = {st_ff.shift_in[12:0], data_i};
        nxt_st.cnt = st_ff.cnt + 4'h1;
      end
    end else begin
      // R02: shifter moves out msb first
      nxt_st.cnt = 4'h0;
      nxt_st.serial_out_shifter = {st_ff.serial_out_shifter[14:0], 1'b0};
    end
    // a fresh load beats a shift on the same edge
    if (st_ff.ld_sync2 != st_ff.ld_seen) begin
      nxt_st.serial_out_shifter = lnk.load_word;
      nxt_st.ld_seen = st_ff.ld_sync2;
    end
  end

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign data_o = st_ff.serial_out_shifter[15];
  assign lnk.shift_bit = st_ff.serial_out_shifter[15];
  assign lnk.frame_word = st_ff.frame_word;
  assign lnk.frame_tgl = st_ff.frame_tgl;

  default clocking cb @(posedge link_clk_i); endclocking
  default disable iff (rst_i);

  property p_cnt_range;
    st_ff.cnt <= LAST_BIT_CNT;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("bit count past frame end"); // R01

  property p_frame_done;
    rw_i && st_ff.cnt == LAST_BIT_CNT |=>
      st_ff.frame_tgl != $past(st_ff.frame_tgl) && st_ff.frame_word[0] == $past(data_i);
  endproperty
  a_frame_done: assert property (p_frame_done) else $error("frame not committed"); // R18

  property p_read_shift;
    !rw_i && st_ff.ld_sync2 == st_ff.ld_seen |=> data_o == $past(st_ff.serial_out_shifter[14]);
  endproperty
  a_read_shift: assert property (p_read_shift) else $error("read shift wrong"); // R16
endmodule

//--- hw/frb_top.sv
// frb_top: register bank of an FM receiver behind a 3-wire serial bus.
// Assumes status and count words come from logic on CLK_I.
// Summary of operation
// R01: eight write registers, 4-bit address then 11 data bits, 15 clocks.
// R02: 16-bit status/count words leave via shifter; code 1011b routes it out.
// R03: filter trim holds width control 10..6 and center control 4..0.
// R04: host writes zero to counter-2 control at start-up.
// R05: host keeps test, swap, unused and enable bits of counter-2 at zero.
// R06: counter-2 delay code selects stop count 2 up to 32768.
// R07: output select field 10..7 routes one internal circuit to measurement.
// R08: main control bit 6 mutes stereo PLL when one.
// R09: main control bit 5 mutes demodulator PLL when one.
// R10: main control bit 4 low switches on stereo integrator loop.
// R11: main control bit 3 low enables measurement.
// R12: main control bit 2 mutes the audio outputs.
// R13: main control bit 1 enables FM receive circuitry.
// R14: host writes zero to main control bit 0.
// R15: stereo clock register drives 11-bit DAC; larger code lowers frequency.
// R16: read/write select low reads, high writes.
// R17: latch-status bit falling copies status word into the shifter.
// R18: written data takes effect only after all 15 clocks.
`timescale 1ns/1ps
module frb_top (
  // system clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // serial link
  input wire logic LINK_CLK_I,
  input wire logic RW_I,
  input wire logic DATA_I,
  output logic DATA_O,
  output logic DATA_OE_N_O,
  // measured words
  input wire logic [frb_pkg::WORD_BITS-1:0] STATUS_I,
  input wire logic [frb_pkg::WORD_BITS-1:0] COUNT_I,
  // circuits that can be routed to the measurement output
  input wire logic RF_OSC_I,
  input wire logic STEREO_CLK_I,
  input wire logic STEREO_IND_I,
  input wire logic IF_OSC_I,
  output logic MEAS_O,
  // filter trim
  output logic [4:0] WIDTH_FILTER_CTL_O,
  output logic [4:0] CENTER_FILTER_CTL_O,
  // counter 2
  output logic CNT2_ENABLE_O,
  output logic [15:0] CNT2_STOP_O,
  // main receiver control
  output logic [3:0] OUT_SELECT_O,
  output logic STEREO_PLL_MUTE_O,
  output logic DEMOD_PLL_MUTE_O,
  output logic STEREO_INTEGRATOR_ON_N_O,
  output logic MEASURE_ENABLE_N_O,
  output logic AUDIO_MUTE_O,
  output logic RADIO_ENABLE_O,
  // trims and raw control words
  output logic [frb_pkg::DATA_BITS-1:0] STEREO_DAC_O,
  output logic [frb_pkg::DATA_BITS-1:0] LATCH_MODE_CTL_O,
  output logic [frb_pkg::DATA_BITS-1:0] RF_CAP_O,
  output logic [frb_pkg::DATA_BITS-1:0] IF_OSC_TRIM_O,
  output logic [frb_pkg::DATA_BITS-1:0] RF_OSC_TRIM_O
);
  import frb_pkg::*;

  typedef struct packed {
    logic fr_sync1;
    logic fr_sync2;
    logic fr_seen;
    frb_data_t filt;
    frb_data_t cnt2;
    frb_data_t mainc;
    frb_data_t stclk;
    frb_data_t latch;
    frb_data_t rfcap;
    frb_data_t ifosc;
    frb_data_t rfosc;
    logic [15:0] load_word;
    logic load_tgl;
  } frb_core_s;

  frb_core_s st_ff;
  frb_core_s nxt_st;
  frb_link_if lnk ();

  logic frame_evt;
  frb_addr_t frame_addr;
  frb_data_t frame_data;
  logic sts_fall;
  logic cnt_fall;
  logic clr_fall;
  logic meas_mux;
  logic [3:0] sel_code;

  frb_link u_link (
    .link_clk_i(LINK_CLK_I),
    .rst_i(SYS_RST_I),
    .rw_i(RW_I),
    .data_i(DATA_I),
    .data_o(DATA_O),
    .lnk(lnk.link)
  );

  // frame toggle settles long before the next frame can end
  assign frame_evt = st_ff.fr_sync2 != st_ff.fr_seen;
  assign frame_addr = lnk.frame_word[ADDR_MSB:ADDR_LSB];
  assign frame_data = lnk.frame_word[DATA_BITS-1:0];

  // R17: falling latch bits of the latch register
  assign sts_fall = frame_evt && frame_addr == ADDR_LATCH &&
                    st_ff.latch[LATCH_STS_BIT] && !frame_data[LATCH_STS_BIT];
  assign cnt_fall = frame_evt && frame_addr == ADDR_LATCH &&
                    st_ff.latch[LATCH_CNT_BIT] && !frame_data[LATCH_CNT_BIT];
  assign clr_fall = frame_evt && frame_addr == ADDR_LATCH &&
                    st_ff.latch[CLEAR_BIT] && !frame_data[CLEAR_BIT];

  always_comb begin
    nxt_st = st_ff;
    nxt_st.fr_sync1 = lnk.frame_tgl;
    nxt_st.fr_sync2 = st_ff.fr_sync1;
    nxt_st.fr_seen = st_ff.fr_sync2;
    // R01: address decode of a finished frame
    if (frame_evt) begin
      case (frame_addr)
        ADDR_FILTER: begin
          nxt_st.filt = frame_data;
        end
        ADDR_CNT2: begin
          nxt_st.cnt2 = frame_data;
        end
        ADDR_MAIN: begin
          nxt_st.mainc = frame_data;
        end
        ADDR_STCLK: begin
          nxt_st.stclk = frame_data;
        end
        ADDR_LATCH: begin
          nxt_st.latch = frame_data;
        end
        ADDR_RFCAP: begin
          nxt_st.rfcap = frame_data;
        end
        ADDR_IFOSC: begin
          nxt_st.ifosc = frame_data;
        end
        ADDR_RFOSC: begin
          nxt_st.rfosc = frame_data;
        end
        default: begin
          // addresses above 0111b are ignored
          nxt_st.filt = st_ff.filt;
        end
      endcase
    end
    // R17: status latch has priority over counter latch and clear
    if (sts_fall) begin
      nxt_st.load_word = STATUS_I;
      nxt_st.load_tgl = ~st_ff.load_tgl;
    end else if (cnt_fall) begin
      nxt_st.load_word = COUNT_I;
      nxt_st.load_tgl = ~st_ff.load_tgl;
    end else if (clr_fall) begin
      nxt_st.load_word = WORD_RST;
      nxt_st.load_tgl = ~st_ff.load_tgl;
    end
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // load word is held until the next toggle, so the link reads it settled
  assign lnk.load_word = st_ff.load_word;
  assign lnk.load_tgl = st_ff.load_tgl;

  // R16: device drives the data pin only while the host reads
  assign DATA_OE_N_O = RW_I;

  // R03: filter trim fields
  assign WIDTH_FILTER_CTL_O = st_ff.filt[WIDTH_MSB:WIDTH_LSB];
  assign CENTER_FILTER_CTL_O = st_ff.filt[CENTER_MSB:CENTER_LSB];

  // R06: stop count is two times four to the code
  assign CNT2_ENABLE_O = st_ff.cnt2[CNT2_EN_BIT];
  assign CNT2_STOP_O = DELAY_BASE << {st_ff.cnt2[DELAY_MSB:DELAY_LSB], 1'b0};

  // R08: stereo PLL mute
  assign STEREO_PLL_MUTE_O = st_ff.mainc[STPLL_BIT];
  // R09: demodulator PLL mute
  assign DEMOD_PLL_MUTE_O = st_ff.mainc[DEMPLL_BIT];
  // R10: integrator enable, active low
  assign STEREO_INTEGRATOR_ON_N_O = st_ff.mainc[INTEG_BIT];
  // R11: measurement enable, active low
  assign MEASURE_ENABLE_N_O = st_ff.mainc[MEAS_BIT];
  // R12: audio mute
  assign AUDIO_MUTE_O = st_ff.mainc[AUDIO_MUTE_BIT];
  // R13: FM receive enable
  assign RADIO_ENABLE_O = st_ff.mainc[RADIO_BIT];

  // R15: stereo clock DAC code
  assign STEREO_DAC_O = st_ff.stclk;
  assign LATCH_MODE_CTL_O = st_ff.latch;
  assign RF_CAP_O = st_ff.rfcap;
  assign IF_OSC_TRIM_O = st_ff.ifosc;
  assign RF_OSC_TRIM_O = st_ff.rfosc;

  assign sel_code = st_ff.mainc[SEL_MSB:SEL_LSB];
  assign OUT_SELECT_O = sel_code;

  // R07: measurement routing; signals are routed, not sampled
  always_comb begin
    case (sel_code)
      SEL_RF_OSC: meas_mux = RF_OSC_I;
      SEL_STEREO_CLK: meas_mux = STEREO_CLK_I;
      SEL_STEREO_IND: meas_mux = STEREO_IND_I;
      SEL_IF_OSC: meas_mux = IF_OSC_I;
      // R02: shifter serial output
      SEL_SHIFTER: meas_mux = lnk.shift_bit;
      default: meas_mux = 1'b0;
    endcase
  end

  // R11: measurement gated by its active-low enable
  assign MEAS_O = meas_mux && !st_ff.mainc[MEAS_BIT];

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_main_write;
    frame_evt && frame_addr == ADDR_MAIN;
  endsequence

  sequence s_status_fall;
    frame_evt && frame_addr == ADDR_LATCH && st_ff.latch[LATCH_STS_BIT] &&
      !frame_data[LATCH_STS_BIT];
  endsequence

  property p_main_commit;
    s_main_write |=> AUDIO_MUTE_O == $past(frame_data[AUDIO_MUTE_BIT]) &&
      RADIO_ENABLE_O == $past(frame_data[RADIO_BIT]);
  endproperty
  a_main_commit: assert property (p_main_commit) else $error("main write lost"); // R01

  property p_no_write_hold;
    !frame_evt |=> $stable(STEREO_DAC_O) && $stable(WIDTH_FILTER_CTL_O);
  endproperty
  a_no_write_hold: assert property (p_no_write_hold) else $error("register moved"); // R18

  property p_filter_split;
    frame_evt && frame_addr == ADDR_FILTER |=>
      WIDTH_FILTER_CTL_O == $past(frame_data[10:6]) &&
      CENTER_FILTER_CTL_O == $past(frame_data[4:0]);
  endproperty
  a_filter_split: assert property (p_filter_split) else $error("filter fields wrong"); // R03

  property p_stop_count;
    $onehot(CNT2_STOP_O) && CNT2_STOP_O >= 16'h0002 && !CNT2_STOP_O[0];
  endproperty
  a_stop_count: assert property (p_stop_count) else $error("stop count invalid"); // R06

  property p_delay_zero;
    st_ff.cnt2[3:1] == 3'h0 |-> CNT2_STOP_O == 16'h0002;
  endproperty
  a_delay_zero: assert property (p_delay_zero) else $error("code zero not count 2"); // R06

  property p_sel_none;
    OUT_SELECT_O == SEL_NONE |-> !MEAS_O;
  endproperty
  a_sel_none: assert property (p_sel_none) else $error("output with none selected"); // R07

  property p_sel_shift;
    OUT_SELECT_O == SEL_SHIFTER && !MEASURE_ENABLE_N_O |-> MEAS_O == lnk.shift_bit;
  endproperty
  a_sel_shift: assert property (p_sel_shift) else $error("shifter not routed"); // R02

  property p_meas_off;
    MEASURE_ENABLE_N_O |-> !MEAS_O;
  endproperty
  a_meas_off: assert property (p_meas_off) else $error("measure while disabled"); // R11

  property p_pll_mutes;
    s_main_write |=> STEREO_PLL_MUTE_O == $past(frame_data[6]) &&
      DEMOD_PLL_MUTE_O == $past(frame_data[5]) &&
      STEREO_INTEGRATOR_ON_N_O == $past(frame_data[4]);
  endproperty
  a_pll_mutes: assert property (p_pll_mutes) else $error("mute bits wrong"); // R08 R09 R10

  property p_status_latch;
    s_status_fall |=> st_ff.load_word == $past(STATUS_I) &&
      st_ff.load_tgl != $past(st_ff.load_tgl);
  endproperty
  a_status_latch: assert property (p_status_latch) else $error("status not latched"); // R17

  property p_dac_write;
    frame_evt && frame_addr == ADDR_STCLK |=> STEREO_DAC_O == $past(frame_data);
  endproperty
  a_dac_write: assert property (p_dac_write) else $error("stereo DAC not written"); // R15

  property p_route_rf;
    OUT_SELECT_O == SEL_RF_OSC && !MEASURE_ENABLE_N_O |-> MEAS_O == RF_OSC_I;
  endproperty
  a_route_rf: assert property (p_route_rf) else $error("rf oscillator not routed"); // R07

  property p_high_addr;
    frame_evt && frame_addr[3] |=> $stable(RF_OSC_TRIM_O) && $stable(LATCH_MODE_CTL_O) &&
      $stable(CENTER_FILTER_CTL_O);
  endproperty
  a_high_addr: assert property (p_high_addr) else $error("high address was stored"); // R01
endmodule

//--- verification/frb_host_model.sv
// frb_host_model: host side of the 3-wire bus; makes link clock, rw and data.
// Assumes the device samples rw and data on the rising link clock edge.
`timescale 1ns/1ps
module frb_host_model (
  // bus pins
  output logic link_clk_o,
  output logic rw_o,
  output logic data_o,
  input wire logic data_i
);
  localparam realtime HALF = 62.5;

  // clock stands low between frames
  initial begin
    link_clk_o = 1'b0;
    rw_o = 1'b1;
    data_o = 1'b0;
  end

  task automatic pulse();
    #(HALF) link_clk_o = 1'b1;
    #(HALF) link_clk_o = 1'b0;
  endtask

  // rw high, address then data, msb first
  task automatic send(input logic [3:0] a, input logic [10:0] d, input int nbits);
    logic [14:0] frame;
    frame = {a, d};
    #0.7;
    rw_o = 1'b1;
    for (int i = 14; i > 14 - nbits; i--) begin
      data_o = frame[i];
      pulse();
    end
    // released line must not show a stale bit
    data_o = ~data_o;
  endtask

  // rw low reads; these edges also let a latched word load
  task automatic idle_read(input int n);
    #0.7;
    rw_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      pulse();
    end
  endtask

  // bit 15 is visible before the first read edge
  task automatic recv(output logic [15:0] word);
    for (int i = 15; i >= 0; i--) begin
      #(HALF - 1.0) word[i] = data_i;
      #1.0 link_clk_o = 1'b1;
      #(HALF) link_clk_o = 1'b0;
    end
    rw_o = 1'b1;
  endtask
endmodule

//--- verification/frb_top_tb.sv
// frb_top_tb: scenarios for the radio register bank over its serial bus.
// Assumes register outputs settle within 4 system cycles after a frame.
`timescale 1ns/1ps
module frb_top_tb;
  import frb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] status_w = 16'hA5C3;
  logic [15:0] count_w = 16'h3C5A;
  logic [3:0] src = 4'h0;
  logic link_clk, rw, host_data, wire_data;
  logic data_o, oe_n, meas, cnt2_en, stpll, dempll, integ_n, meas_n, audio_mute, radio;
  logic [4:0] wf, cf;
  logic [3:0] osel;
  logic [15:0] stop, w;
  frb_data_t raw [3:7];
  int fail_count = 0;
  int checks = 0;
  wire [9:0] main_v = {osel, stpll, dempll, integ_n, meas_n, audio_mute, radio};

  always #2.5 clk = ~clk;
  // wire level from both drivers
  assign wire_data = (oe_n === 1'b0) ? data_o : host_data;

  frb_host_model host (
    .link_clk_o(link_clk),
    .rw_o(rw),
    .data_o(host_data),
    .data_i(wire_data)
  );

  frb_top dut (
    .CLK_I(clk),
    .SYS_RST_I(rst),
    .LINK_CLK_I(link_clk),
    .RW_I(rw),
    .DATA_I(wire_data),
    .DATA_O(data_o),
    .DATA_OE_N_O(oe_n),
    .STATUS_I(status_w),
    .COUNT_I(count_w),
    .RF_OSC_I(src[0]),
    .STEREO_CLK_I(src[1]),
    .STEREO_IND_I(src[2]),
    .IF_OSC_I(src[3]),
    .MEAS_O(meas),
    .WIDTH_FILTER_CTL_O(wf),
    .CENTER_FILTER_CTL_O(cf),
    .CNT2_ENABLE_O(cnt2_en),
    .CNT2_STOP_O(stop),
    .OUT_SELECT_O(osel),
    .STEREO_PLL_MUTE_O(stpll),
    .DEMOD_PLL_MUTE_O(dempll),
    .STEREO_INTEGRATOR_ON_N_O(integ_n),
    .MEASURE_ENABLE_N_O(meas_n),
    .AUDIO_MUTE_O(audio_mute),
    .RADIO_ENABLE_O(radio),
    .STEREO_DAC_O(raw[3]),
    .LATCH_MODE_CTL_O(raw[4]),
    .RF_CAP_O(raw[5]),
    .IF_OSC_TRIM_O(raw[6]),
    .RF_OSC_TRIM_O(raw[7])
  );

  task automatic complete_run();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input frb_addr_t a, input frb_data_t d);
    host.send(a, d, 15);
    repeat (6) @(negedge clk);
  endtask

  task automatic t_reset();
    chk("stop", 16'h0002, stop);
    chk("main", 16'h0000, main_v);
    chk("oe_n", 16'h0001, oe_n);
    chk("meas", 16'h0000, meas);
  endtask

  task automatic t_filter();
    wr(ADDR_FILTER, 11'h54A);
    chk("width", 16'h0015, wf);
    chk("center", 16'h000A, cf);
    // a frame cut short by a read edge is dropped
    host.send(ADDR_FILTER, 11'h2B5, 14);
    host.idle_read(1);
    repeat (6) @(negedge clk);
    chk("partial", 16'h02AA, {wf, cf});
  endtask

  task automatic t_trims();
    for (int a = 3; a < 8; a++) begin
      wr(frb_addr_t'(a), {a[2:0], 8'hC3});
    end
    // 8 and F alias 0 and 7 if the top address bit is ignored
    wr(4'h8, 11'h7FF);
    wr(4'hF, 11'h7FF);
    for (int a = 3; a < 8; a++) begin
      chk("raw", {a[2:0], 8'hC3}, raw[a]);
    end
    chk("filter", 16'h02AA, {wf, cf});
  endtask

  task automatic t_cnt2();
    logic [15:0] stops [8] = '{16'h0002, 16'h0008, 16'h0020, 16'h0080,
                               16'h0200, 16'h0800, 16'h2000, 16'h8000};
    for (int i = 0; i < 8; i++) begin
      // enable bit stays zero, as the host must keep it
      wr(ADDR_CNT2, {7'h00, i[2:0], 1'b0});
      chk("stop", stops[i], stop);
      chk("cnt2_en", 16'h0000, cnt2_en);
    end
    wr(ADDR_CNT2, 11'h000);
    chk("stop", 16'h0002, stop);
  endtask

  task automatic t_main();
    logic [3:0] codes [5] = '{SEL_NONE, SEL_RF_OSC, SEL_STEREO_CLK, SEL_STEREO_IND, SEL_IF_OSC};
    logic [6:0] low;
    for (int k = 0; k < 5; k++) begin
      for (int p = 0; p < 2; p++) begin
        low = p ? 7'b0100010 : 7'b1010110;
        @(negedge clk);
        // with none selected every source is high, so any leak shows
        src = (codes[k] == SEL_NONE) ? 4'hF :
              {codes[k] == SEL_IF_OSC, codes[k] == SEL_STEREO_IND,
               codes[k] == SEL_STEREO_CLK, codes[k] == SEL_RF_OSC};
        wr(ADDR_MAIN, {codes[k], low});
        chk("main", {codes[k], low[6:1]}, main_v);
        chk("meas", codes[k] != SEL_NONE, meas);
      end
    end
    wr(ADDR_MAIN, {SEL_IF_OSC, 7'b0001000});
    chk("meas", 16'h0000, meas);
    chk("main", {SEL_IF_OSC, 6'b000100}, main_v);
  endtask

  task automatic t_latch(input frb_data_t d, input logic [15:0] exp);
    wr(ADDR_LATCH, d);
    wr(ADDR_LATCH, 11'h000);
    // later changes at the source must not reach the shifter
    status_w = ~status_w;
    count_w = ~count_w;
    host.idle_read(3);
    @(negedge clk);
    chk("oe_n", 16'h0000, oe_n);
    chk("meas", exp[15], meas);
    host.recv(w);
    chk("word", exp, w);
  endtask

  initial begin
    #400000;
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset();
    wr(ADDR_CNT2, 11'h000);
    t_filter();
    t_trims();
    t_cnt2();
    t_main();
    wr(ADDR_MAIN, {SEL_SHIFTER, 7'b1010110});
    t_latch(11'h200, status_w);
    t_latch(11'h400, count_w);
    t_latch(11'h010, 16'h0000);
    complete_run();
  end
endmodule
